// File: include/pin_arb_pkg.sv
// Purpose: constants shared by the pin function arbiter and its bench
// Assumes: register bus with 5-bit word index, 16-bit data
// Notes: change-notification registers are storage only
package pin_arb_pkg;
	localparam int PIN_COUNT = 16;
	localparam int ADDR_W = 5;
	localparam int SEL_W = 6;
	// register indices, port a then port b
	localparam logic [ADDR_W-1:0] REG_A_ANALOG = 5'h00;
	localparam logic [ADDR_W-1:0] REG_A_DIR = 5'h01;
	localparam logic [ADDR_W-1:0] REG_A_LEVEL = 5'h02;
	localparam logic [ADDR_W-1:0] REG_A_LATCH = 5'h03;
	localparam logic [ADDR_W-1:0] REG_A_ODC = 5'h04;
	localparam logic [ADDR_W-1:0] REG_A_PU = 5'h05;
	localparam logic [ADDR_W-1:0] REG_A_PD = 5'h06;
	localparam logic [ADDR_W-1:0] REG_A_CNCTL = 5'h07;
	localparam logic [ADDR_W-1:0] REG_A_CNEN0 = 5'h08;
	localparam logic [ADDR_W-1:0] REG_A_CNSTAT = 5'h09;
	localparam logic [ADDR_W-1:0] REG_A_CNEN1 = 5'h0a;
	localparam logic [ADDR_W-1:0] REG_A_CNFLAG = 5'h0b;
	localparam logic [ADDR_W-1:0] PORT_B_BASE = 5'h10;
	// remap selector base: four slots per port, each reaching two pins of port b
	localparam logic [ADDR_W-1:0] REMAP_BASE_IDX = 5'h0c;
	// reset values
	localparam logic [15:0] ANALOG_A_RST = 16'h001f;
	localparam logic [15:0] ANALOG_B_RST = 16'h038f;
	localparam logic [15:0] DIR_RST = 16'hffff;
	localparam logic [15:0] ZERO_RST = 16'h0000;
	localparam logic [SEL_W-1:0] SEL_DEFAULT_PORT = 6'h00;
endpackage

// File: design/io_pin_function_arbiter.sv
// Purpose: per-pin function arbitration for two 16-bit i/o ports
// Assumes: pins pass two flip-flops before use; one clock domain
// Notes: pin side is split into level in, level out and output enable
`timescale 1ns/1ps
`default_nettype none
module io_pin_function_arbiter
	import pin_arb_pkg::*;
#(
	parameter int NPIN = PIN_COUNT,
	parameter int NPERIPH = 64,
	parameter int NRIN = 8
)
(
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic clk_en_i,
	// register port
	input wire logic [pin_arb_pkg::ADDR_W-1:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [15:0] reg_rdata_o,
	// pins, port a and port b
	input wire logic [NPIN-1:0] pin_a_i,
	output logic [NPIN-1:0] pin_a_o,
	output logic [NPIN-1:0] pin_a_oe_o,
	output logic [NPIN-1:0] pull_up_a_o,
	output logic [NPIN-1:0] pull_down_a_o,
	input wire logic [NPIN-1:0] pin_b_i,
	output logic [NPIN-1:0] pin_b_o,
	output logic [NPIN-1:0] pin_b_oe_o,
	output logic [NPIN-1:0] pull_up_b_o,
	output logic [NPIN-1:0] pull_down_b_o,
	// dedicated functions per pin of port b
	input wire logic [NPIN-1:0] ded_analog_en_i,
	input wire logic [NPIN-1:0] ded_out_en_i,
	input wire logic [NPIN-1:0] ded_out_i,
	// peripheral outputs, index 0 unused (default port)
	input wire logic [NPERIPH-1:0] periph_out_i,
	// remappable inputs: pin index per input, and resulting level
	input wire logic [NRIN*4-1:0] rin_sel_i,
	output logic [NRIN-1:0] rin_level_o,
	// digital input levels for dedicated inputs
	output logic [NPIN-1:0] din_a_o,
	output logic [NPIN-1:0] din_b_o
);
	import pin_arb_pkg::*;

	logic [15:0] analog [2];
	logic [15:0] dir [2];
	logic [15:0] latch [2];
	logic [15:0] odc [2];
	logic [15:0] pu [2];
	logic [15:0] pd [2];
	logic [15:0] cn [2][5];
	logic [SEL_W-1:0] remap_sel [NPIN];
	logic [NPIN-1:0] sync1_a, sync1_b, sync_a, sync_b;
	logic [15:0] din [2];
	logic [15:0] next_rdata;

	// port select and local index of an address
	function automatic logic port_of(input logic [ADDR_W-1:0] a);
		port_of = a[4];
	endfunction
	function automatic logic [3:0] idx_of(input logic [ADDR_W-1:0] a);
		idx_of = a[3:0];
	endfunction

	// two-stage synchroniser on pin levels
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			sync1_a <= '0;
			sync1_b <= '0;
			sync_a <= '0;
			sync_b <= '0;
		end
		else if (clk_en_i)
		begin
			sync1_a <= pin_a_i;
			sync1_b <= pin_b_i;
			sync_a <= sync1_a;
			sync_b <= sync1_b;
		end
	end

	// register map, index within a port; port b adds 0x10:
	//   0x0 analog select   0x1 direction       0x2 pin level
	//   0x3 output latch    0x4 open drain      0x5 pull-up enable
	//   0x6 pull-down       0x7 change control  0x8 change enable 0
	//   0x9 change state    0xa change enable 1 0xb change flags
	//   0xc..0xf remap selectors, write-only
	// one process per register array keeps each array on a single driver
	logic wr_go;
	logic wr_port;
	logic [3:0] wr_idx;
	assign wr_go = clk_en_i & reg_wr_i;
	assign wr_port = port_of(reg_addr_i);
	assign wr_idx = idx_of(reg_addr_i);

	// analog select: shared pins wake up analog, so their input
	// buffers stay off until software frees them for digital use
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			analog[0] <= ANALOG_A_RST;
			analog[1] <= ANALOG_B_RST;
		end
		else if (wr_go && wr_idx == REG_A_ANALOG[3:0])
		begin
			analog[wr_port] <= reg_wdata_i;
		end
	end

	// direction: all inputs after reset, so no port driver wakes up
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			dir[0] <= DIR_RST;
			dir[1] <= DIR_RST;
		end
		else if (wr_go && wr_idx == REG_A_DIR[3:0])
		begin
			dir[wr_port] <= reg_wdata_i;
		end
	end

	// output latch; a write to the level register lands here as well,
	// since a pin level itself cannot be stored
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			latch[0] <= ZERO_RST;
			latch[1] <= ZERO_RST;
		end
		else if (wr_go && (wr_idx == REG_A_LEVEL[3:0] ||
			wr_idx == REG_A_LATCH[3:0]))
		begin
			latch[wr_port] <= reg_wdata_i;
		end
	end

	// open drain: a set bit turns the pin driver into a pull-low only
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			odc[0] <= ZERO_RST;
			odc[1] <= ZERO_RST;
		end
		else if (wr_go && wr_idx == REG_A_ODC[3:0])
		begin
			odc[wr_port] <= reg_wdata_i;
		end
	end

	// weak pull-ups, one bit per pin
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			pu[0] <= ZERO_RST;
			pu[1] <= ZERO_RST;
		end
		else if (wr_go && wr_idx == REG_A_PU[3:0])
		begin
			pu[wr_port] <= reg_wdata_i;
		end
	end

	// weak pull-downs; with both pulls set the pad only sees a
	// resistor divider, which software has to avoid
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			pd[0] <= ZERO_RST;
			pd[1] <= ZERO_RST;
		end
		else if (wr_go && wr_idx == REG_A_PD[3:0])
		begin
			pd[wr_port] <= reg_wdata_i;
		end
	end

	// change-notification registers are plain storage here; slot 2 is
	// the read-only change state and keeps its reset value
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			for (int k = 0; k < 5; k++)
			begin
				cn[0][k] <= ZERO_RST;
				cn[1][k] <= ZERO_RST;
			end
		end
		else if (wr_go)
		begin
			case (wr_idx)
				REG_A_CNCTL[3:0]: cn[wr_port][0] <= reg_wdata_i;
				REG_A_CNEN0[3:0]: cn[wr_port][1] <= reg_wdata_i;
				REG_A_CNEN1[3:0]: cn[wr_port][3] <= reg_wdata_i;
				REG_A_CNFLAG[3:0]: cn[wr_port][4] <= reg_wdata_i;
				default: ;
			endcase
		end
	end

	// remap selectors sit in the spare slots 0xc..0xf of each port;
	// slot, port bit and write data bit 15 pick one of sixteen port b
	// pins: port a slots reach pins 0..7, port b slots pins 8..15
	// the base is a multiple of four, so the low address bits are the
	// slot; selectors are write-only and read back as zero
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			for (int n = 0; n < NPIN; n++)
				remap_sel[n] <= SEL_DEFAULT_PORT;
		end
		else if (wr_go && wr_idx >= REMAP_BASE_IDX[3:0])
		begin
			// no lock bit: any mapping is accepted at any time
			remap_sel[{wr_port, reg_addr_i[1:0], reg_wdata_i[15]}] <=
				reg_wdata_i[SEL_W-1:0];
		end
	end

	// input buffer: analog select, and on port b dedicated analog use, gate it, never direction
	always_comb
	begin
		din[0] = sync_a & ~analog[0];
		din[1] = sync_b & ~analog[1] & ~ded_analog_en_i;
	end
	assign din_a_o = din[0];
	assign din_b_o = din[1];

	// remappable inputs read port b levels; any number may share a
	// pin, and dedicated digital use on it does not block them
	genvar r;
	generate
		for (r = 0; r < NRIN; r++)
		begin : g_rin
			assign rin_level_o[r] = din[1][rin_sel_i[r*4 +: 4]];
		end
	endgenerate

	// port b output arbitration, one source per pin by priority:
	// dedicated output, then remapped peripheral, then port latch
	genvar n;
	generate
		for (n = 0; n < NPIN; n++)
		begin : g_pin
			logic drv, val, rmp;
			// same peripheral index may appear in many selectors
			assign rmp = (remap_sel[n] != SEL_DEFAULT_PORT);
			always_comb
			begin
				if (ded_out_en_i[n])
				begin
					val = ded_out_i[n];
					drv = 1'b1;
				end
				else if (rmp)
				begin
					val = periph_out_i[remap_sel[n]];
					drv = 1'b1;
				end
				else
				begin
					// port driver obeys direction, even on analog pins
					val = latch[1][n];
					drv = ~dir[1][n];
				end
			end
			// open drain: drive only lows
			assign pin_b_o[n] = odc[1][n] ? 1'b0 : val;
			assign pin_b_oe_o[n] = drv & (odc[1][n] ? ~val : 1'b1);
			// port a has no remappable pins: latch under direction
			assign pin_a_o[n] = odc[0][n] ? 1'b0 : latch[0][n];
			assign pin_a_oe_o[n] = ~dir[0][n] &
				(odc[0][n] ? ~latch[0][n] : 1'b1);
		end
	endgenerate

	assign pull_up_a_o = pu[0];
	assign pull_down_a_o = pd[0];
	assign pull_up_b_o = pu[1];
	assign pull_down_b_o = pd[1];

	// read mux; unmapped slots answer zero
	always_comb
	begin
		logic p;
		p = port_of(reg_addr_i);
		case (idx_of(reg_addr_i))
			REG_A_ANALOG[3:0]: next_rdata = analog[p];
			REG_A_DIR[3:0]: next_rdata = dir[p];
			REG_A_LEVEL[3:0]: next_rdata = din[p];
			REG_A_LATCH[3:0]: next_rdata = latch[p] & ~analog[p];
			REG_A_ODC[3:0]: next_rdata = odc[p];
			REG_A_PU[3:0]: next_rdata = pu[p];
			REG_A_PD[3:0]: next_rdata = pd[p];
			REG_A_CNCTL[3:0]: next_rdata = cn[p][0];
			REG_A_CNEN0[3:0]: next_rdata = cn[p][1];
			REG_A_CNSTAT[3:0]: next_rdata = cn[p][2];
			REG_A_CNEN1[3:0]: next_rdata = cn[p][3];
			REG_A_CNFLAG[3:0]: next_rdata = cn[p][4];
			default: next_rdata = ZERO_RST;
		endcase
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			reg_rdata_o <= ZERO_RST;
		else if (clk_en_i)
			reg_rdata_o <= reg_rd_i ? next_rdata : ZERO_RST;
	end

endmodule
`default_nettype wire

// File: testbench/pin_arb_asserts.sv
// Purpose: port-level checks of the pin function arbiter
// Assumes: one clock, async active-low reset, clock enable held high
// Notes: wr_seen closes the reset-state window at the first write
`timescale 1ns/1ps
`default_nettype none
module pin_arb_asserts
	import pin_arb_pkg::*;
#(parameter int NPIN = 16, parameter int NRIN = 8)
(
	// clock, reset, register port
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic [pin_arb_pkg::ADDR_W-1:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [15:0] reg_rdata_o,
	// pins and functions
	input wire logic [NPIN-1:0] pull_up_a_o,
	input wire logic [NPIN-1:0] pin_b_o,
	input wire logic [NPIN-1:0] pin_b_oe_o,
	input wire logic [NPIN-1:0] ded_analog_en_i,
	input wire logic [NPIN-1:0] ded_out_en_i,
	input wire logic [NPIN-1:0] ded_out_i,
	input wire logic [NRIN*4-1:0] rin_sel_i,
	input wire logic [NRIN-1:0] rin_level_o,
	input wire logic [NPIN-1:0] din_a_o,
	input wire logic [NPIN-1:0] din_b_o
);
	// registers still hold reset values until the first write lands
	logic wr_seen;
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			wr_seen <= 1'b0;
		else if (reg_wr_i)
			wr_seen <= 1'b1;
	end
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	property p_rst_ana; !wr_seen |-> ~|(din_a_o & ANALOG_A_RST) &&
		~|(din_b_o & ANALOG_B_RST); endproperty
	a_rst_ana: assert property (p_rst_ana)
		else $error("analog pin seen as digital after reset");
	property p_rst_out; !wr_seen |-> ~|(pin_b_oe_o & ~ded_out_en_i) &&
		~|pull_up_a_o; endproperty
	a_rst_out: assert property (p_rst_out)
		else $error("pin driven before any setup");
	property p_rd_idle; !$past(reg_rd_i) |-> reg_rdata_o == '0; endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data outside its cycle");
	property p_lvl; reg_rd_i && reg_addr_i == REG_A_LEVEL |=>
		reg_rdata_o == $past(din_a_o); endproperty
	a_lvl: assert property (p_lvl)
		else $error("level read differs from masked pins");
	property p_pull; reg_wr_i && reg_addr_i == REG_A_PU |=>
		pull_up_a_o == $past(reg_wdata_i); endproperty
	a_pull: assert property (p_pull)
		else $error("pull-up output not from register");
	property p_ded_oe; ~|(ded_out_en_i & ~ded_out_i & ~pin_b_oe_o); endproperty
	a_ded_oe: assert property (p_ded_oe)
		else $error("dedicated output not driving");
	property p_ded_v; ~|((pin_b_o ^ ded_out_i) & ded_out_en_i & pin_b_oe_o);
	endproperty
	a_ded_v: assert property (p_ded_v)
		else $error("dedicated output lost to another source");
	property p_ded_an; ~|(din_b_o & ded_analog_en_i); endproperty
	a_ded_an: assert property (p_ded_an)
		else $error("digital input live under analog function");
	property p_share; rin_sel_i[3:0] == rin_sel_i[7:4] |->
		rin_level_o[0] == rin_level_o[1]; endproperty
	a_share: assert property (p_share)
		else $error("inputs on one pin disagree");
endmodule
bind io_pin_function_arbiter pin_arb_asserts #(.NPIN(NPIN), .NRIN(NRIN))
	i_pin_arb_asserts (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
	.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
	.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
	.pull_up_a_o(pull_up_a_o), .pin_b_o(pin_b_o), .pin_b_oe_o(pin_b_oe_o),
	.ded_analog_en_i(ded_analog_en_i), .ded_out_en_i(ded_out_en_i),
	.ded_out_i(ded_out_i), .rin_sel_i(rin_sel_i),
	.rin_level_o(rin_level_o), .din_a_o(din_a_o), .din_b_o(din_b_o));
`default_nettype wire

// File: testbench/board_pins.sv
// Purpose: board-side model of one 16-pin port
// Assumes: an undriven pin without pulls follows the outside source
// Notes: pull-up wins if both pulls are on, a weak-resistor fight
`timescale 1ns/1ps
`default_nettype none
module board_pins
(
	// device side and outside source
	input wire logic [15:0] out_i,
	input wire logic [15:0] oe_i,
	input wire logic [15:0] pu_i,
	input wire logic [15:0] pd_i,
	input wire logic [15:0] ext_i,
	output logic [15:0] level_o
);
	// driver first, then weak pulls, then the outside level
	assign level_o = (oe_i & out_i) | (~oe_i & pu_i)
		| (~oe_i & ~pu_i & ~pd_i & ext_i);
endmodule
`default_nettype wire

// File: testbench/io_pin_function_arbiter_test.sv
// Purpose: register-driven tests of the pin function arbiter
// Assumes: clock enable held high throughout
// Notes: level reads wait for the two-flop pin synchroniser
`timescale 1ns/1ps
`default_nettype none
module io_pin_function_arbiter_test;
	import pin_arb_pkg::*;
	logic core_clk_i = 0, rst_n_i = 0, wr = 0, rd = 0;
	logic [4:0] addr = 0;
	logic [15:0] wdata = 0, rdata, pa, pa_o, pa_oe, pu_a, pd_a, din_a;
	logic [15:0] pb, pb_o, pb_oe, pu_b, pd_b, din_b, dan = 0, den = 0;
	logic [15:0] dout = 0, ext_a = 16'hffff, ext_b = 0;
	logic [63:0] periph = 64'h0000_0000_0000_0020;
	logic [31:0] rsel = 32'h7654_3210;
	logic [7:0] rlvl;
	int err_count = 0, checks = 0;
	localparam logic [4:0] B = PORT_B_BASE;
	always #2.5 core_clk_i = ~core_clk_i;
	io_pin_function_arbiter i_io_pin_function_arbiter (
		.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .clk_en_i(1'b1),
		.reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
		.reg_rd_i(rd), .reg_rdata_o(rdata), .pin_a_i(pa), .pin_a_o(pa_o),
		.pin_a_oe_o(pa_oe), .pull_up_a_o(pu_a), .pull_down_a_o(pd_a),
		.pin_b_i(pb), .pin_b_o(pb_o), .pin_b_oe_o(pb_oe),
		.pull_up_b_o(pu_b), .pull_down_b_o(pd_b), .ded_analog_en_i(dan),
		.ded_out_en_i(den), .ded_out_i(dout), .periph_out_i(periph),
		.rin_sel_i(rsel), .rin_level_o(rlvl), .din_a_o(din_a),
		.din_b_o(din_b));
	board_pins i_board_pins_a (.out_i(pa_o), .oe_i(pa_oe), .pu_i(pu_a),
		.pd_i(pd_a), .ext_i(ext_a), .level_o(pa));
	board_pins i_board_pins_b (.out_i(pb_o), .oe_i(pb_oe), .pu_i(pu_b),
		.pd_i(pd_b), .ext_i(ext_b), .level_o(pb));
	// compare and count
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("MISMATCH %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	// one idle edge after each strobe keeps drives single per step
	task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge core_clk_i);
		wr <= 1'b0;
		@(posedge core_clk_i);
	endtask
	task automatic rd_reg(input logic [4:0] a, input logic [15:0] e);
		addr <= a;
		rd <= 1'b1;
		@(posedge core_clk_i);
		rd <= 1'b0;
		#1 chk(rdata, e);
		@(posedge core_clk_i);
	endtask
	task automatic remap(input logic [3:0] p, input logic [5:0] v);
		wr_reg({p[3], 2'b11, p[2:1]}, {p[0], 9'h000, v});
	endtask
	task automatic end_sim;
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// hang guard, far beyond the fewer than one hundred cycles of tests
	initial
	begin
		#100us;
		err_count++;
		end_sim();
	end
	initial
	begin
		repeat (16) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		@(posedge core_clk_i);
		rd_reg(REG_A_ANALOG, ANALOG_A_RST);
		rd_reg(B | REG_A_ANALOG, ANALOG_B_RST);
		rd_reg(REG_A_DIR, DIR_RST);
		wr_reg(REG_A_CNSTAT, 16'hffff);
		rd_reg(REG_A_CNSTAT, ZERO_RST);
		rd_reg(REMAP_BASE_IDX, ZERO_RST);
		chk(pb_oe, 16'h0000);
		rd_reg(REG_A_LEVEL, ~ANALOG_A_RST);
		wr_reg(REG_A_LATCH, 16'h00ff);
		rd_reg(REG_A_LATCH, 16'h00ff & ~ANALOG_A_RST);
		wr_reg(REG_A_ANALOG, ZERO_RST);
		rd_reg(REG_A_LATCH, 16'h00ff);
		rd_reg(REG_A_LEVEL, 16'hffff);
		ext_a <= 16'h0000;
		wr_reg(REG_A_PU, 16'h00f0);
		wr_reg(REG_A_PD, 16'h0f00);
		chk(pd_a, 16'h0f00);
		repeat (3) @(posedge core_clk_i);
		rd_reg(REG_A_LEVEL, 16'h00f0);
		chk(din_a, 16'h00f0);
		wr_reg(B | REG_A_LATCH, 16'haaaa);
		wr_reg(B | REG_A_DIR, 16'h0000);
		chk(pb_oe, 16'hffff);
		chk(pb_o, 16'haaaa);
		repeat (3) @(posedge core_clk_i);
		rd_reg(B | REG_A_LEVEL, 16'haaaa & ~ANALOG_B_RST);
		wr_reg(B | REG_A_DIR, 16'hffff);
		den <= 16'h0001;
		remap(4'h0, 6'h05);
		remap(4'h1, 6'h05);
		remap(4'h2, 6'h05);
		chk(pb_oe, 16'h0007);
		chk(pb_o & 16'h0007, 16'h0006);
		wr_reg(B | REG_A_ANALOG, ZERO_RST);
		dout <= 16'h0001;
		rsel <= 32'h0000_0000;
		repeat (4) @(posedge core_clk_i);
		#1 chk({8'h00, rlvl}, 16'h00ff);
		chk(din_b, 16'h0007);
		dan <= 16'h0001;
		repeat (2) @(posedge core_clk_i);
		#1 chk({8'h00, rlvl}, 16'h0000);
		chk(pb_oe, 16'h0007);
		chk(din_b, 16'h0006);
		wr_reg(B | REG_A_PU, 16'h1234);
		chk(pu_b, 16'h1234);
		wr_reg(B | REG_A_PD, 16'h4321);
		chk(pd_b, 16'h4321);
		// port a: low nibble open drain, low byte set to output with latch 00ff, so only bits 4..7 drive
		wr_reg(REG_A_ODC, 16'h000f);
		wr_reg(REG_A_DIR, 16'hff00);
		chk(pa_oe, 16'h00f0);
		chk(pa_o, 16'h00f0);
		end_sim();
	end
endmodule
`default_nettype wire
